//--- logic/sfp_array.sv
// Byte array of the flash, held in flip-flops
`timescale 1ns/1ps
module sfp_array
  import sfp_pkg::*;
#(
  parameter int ADDR_W = SFP_ADDR_W
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic wr_en_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [7:0] rd_data_out
);

  logic [7:0] mem_reg [2**ADDR_W];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
        mem_reg[i] <= ERASED_BYTE;
      end
    end else if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  // Read is unclocked; callers only read while no write runs
  assign rd_data_out = mem_reg[rd_addr_in];

endmodule : sfp_array

//--- logic/sfp_flash_core.sv
// Serial flash command logic: reads, wipes, status update and locking
`timescale 1ns/1ps
module sfp_flash_core
  import sfp_pkg::*;
#(
  parameter int ADDR_W = SFP_ADDR_W,
  parameter int SECTOR_WIPE_TIME_US = 30000,
  parameter int HALF_BLOCK_WIPE_TIME_US = 120000,
  parameter int STATUS_UPDATE_TIME_US = 10000
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic sclk_in,
  input wire logic cs_b_in,
  input wire logic wp_b_in,
  input wire logic io_line_zero_in,
  input wire logic io_line_one_in,
  output logic io_line_zero_out,
  output logic io_line_zero_oe_out,
  output logic io_line_one_out,
  output logic io_line_one_oe_out,
  input wire logic load_en_in,
  input wire logic [ADDR_W-1:0] load_addr_in,
  input wire logic [7:0] load_data_in,
  output logic status_lock_bit_out,
  output logic protect_level_top_out,
  output logic protect_level_mid_out,
  output logic protect_level_low_out,
  output logic write_enable_latch_out,
  output logic busy_flag_out,
  output logic hardware_locked_state_out,
  output logic software_locked_state_out
);

  localparam int SECTOR_WIPE_CYC = SECTOR_WIPE_TIME_US * SYS_CLK_MHZ;
  localparam int HALF_BLOCK_WIPE_CYC = HALF_BLOCK_WIPE_TIME_US * SYS_CLK_MHZ;
  localparam int STATUS_UPDATE_CYC = STATUS_UPDATE_TIME_US * SYS_CLK_MHZ;
  localparam logic [ADDR_W-1:0] SECT_MASK = ADDR_W'((32'h1 << SECTOR_SHIFT) - 1);
  localparam logic [ADDR_W-1:0] HALF_MASK = ADDR_W'((32'h1 << HALF_BLOCK_SHIFT) - 1);

  // ----------------------------------------------------------------
  // Link side state
  // ----------------------------------------------------------------
  logic frame_rst_b;
  logic in_frame_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] edge_idx;
  logic [7:0] opc_reg;
  logic [23:0] addr_reg;
  logic [2:0] dpos_reg;
  logic [2:0] dpos_last;
  logic rd_allow_reg;
  logic busy_s1_reg;
  logic busy_s2_reg;
  logic frame_tog_reg;
  logic [7:0] out_shift_reg;
  logic [7:0] out_byte;
  logic [7:0] rd_data;
  logic rd_cmd;
  logic dual_cmd;
  logic dio_cmd;
  logic data_phase;

  // Select high clears the frame, so outputs drop with no clock edge
  assign frame_rst_b = rst_b_in & ~cs_b_in;
  assign edge_idx = in_frame_reg ? cnt_reg : '0;
  assign rd_cmd = sfp_is_read(opc_reg);
  assign dual_cmd = sfp_is_dual(opc_reg);
  assign dio_cmd = opc_reg == DUAL_IO_READ_CMD;
  assign dpos_last = dual_cmd ? DPOS_LAST_DUAL : DPOS_LAST_SGL;
  assign data_phase = in_frame_reg && rd_cmd && cnt_reg >= sfp_data_start(opc_reg);
  assign out_byte = (dpos_reg == '0) ? rd_data : out_shift_reg;

  always_ff @(posedge sclk_in or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      in_frame_reg <= 1'b0;
    end else begin
      in_frame_reg <= 1'b1;
    end
  end

  // Frame registers survive select high so the system side can read them
  always_ff @(posedge sclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg <= '0;
      frame_tog_reg <= 1'b0;
    end else if (!in_frame_reg) begin
      cnt_reg <= CNT_ONE;
      frame_tog_reg <= ~frame_tog_reg;
    end else if (cnt_reg != CNT_MAX) begin
      cnt_reg <= cnt_reg + CNT_ONE;
    end
  end

  always_ff @(posedge sclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      opc_reg <= '0;
    end else if (edge_idx < EDGE_OPC_END) begin
      opc_reg <= {opc_reg[6:0], io_line_zero_in};
    end
  end

  always_ff @(posedge sclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_allow_reg <= 1'b0;
    end else if (edge_idx == EDGE_OPC_LAST) begin
      rd_allow_reg <= ~busy_s2_reg;
    end
  end

  always_ff @(posedge sclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_s1_reg <= 1'b0;
      busy_s2_reg <= 1'b0;
    end else begin
      busy_s1_reg <= busy_flag_out;
      busy_s2_reg <= busy_s1_reg;
    end
  end

  always_ff @(posedge sclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_reg <= '0;
    end else if (dio_cmd && edge_idx >= EDGE_OPC_END && edge_idx < EDGE_DIO_ADDR_END) begin
      addr_reg <= {addr_reg[21:0], io_line_one_in, io_line_zero_in};
    end else if (!dio_cmd && edge_idx >= EDGE_OPC_END && edge_idx < EDGE_ADDR_END) begin
      addr_reg <= {addr_reg[22:0], io_line_zero_in};
    end else if (data_phase && dpos_reg == dpos_last) begin
      addr_reg[ADDR_W-1:0] <= addr_reg[ADDR_W-1:0] + ADDR_W'(1);
    end
  end

  always_ff @(posedge sclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dpos_reg <= '0;
    end else if (!data_phase || dpos_reg == dpos_last) begin
      dpos_reg <= '0;
    end else begin
      dpos_reg <= dpos_reg + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Link output, falling edges
  // ----------------------------------------------------------------
  // select high releases outputs
  always_ff @(negedge sclk_in or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      out_shift_reg <= '0;
      io_line_zero_out <= 1'b0;
      io_line_zero_oe_out <= 1'b0;
      io_line_one_out <= 1'b0;
      io_line_one_oe_out <= 1'b0;
    end else if (data_phase && rd_allow_reg && dual_cmd) begin
      io_line_one_out <= out_byte[7];
      io_line_zero_out <= out_byte[6];
      io_line_one_oe_out <= 1'b1;
      io_line_zero_oe_out <= 1'b1;
      out_shift_reg <= {out_byte[5:0], 2'b00};
    // single data after address or dummy byte
    end else if (data_phase && rd_allow_reg) begin
      io_line_one_out <= out_byte[7];
      io_line_one_oe_out <= 1'b1;
      io_line_zero_oe_out <= 1'b0;
      out_shift_reg <= {out_byte[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // System side synchronisers
  // ----------------------------------------------------------------
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic cs_s3_reg;
  logic wp_s1_reg;
  logic wp_s2_reg;
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_seen_reg;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      wp_s1_reg <= 1'b1;
      wp_s2_reg <= 1'b1;
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
    end else begin
      cs_s1_reg <= cs_b_in;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      wp_s1_reg <= wp_b_in;
      wp_s2_reg <= wp_s1_reg;
      tog_s1_reg <= frame_tog_reg;
      tog_s2_reg <= tog_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Frame end decode
  // ----------------------------------------------------------------
  logic frame_end;
  logic op_ok;
  logic hw_lock_now;
  logic go_latch;
  logic go_status;
  logic go_sect;
  logic go_half;
  logic wipe_prot;
  logic [2:0] level;
  logic [ADDR_W-1:0] wipe_mask;
  logic [ADDR_W-1:0] wipe_first;
  logic [ADDR_W-1:0] wipe_last;

  // Frame registers are static once select is high; a fresh toggle
  // proves the frame had clock edges, so stale counts never re-run
  assign frame_end = cs_s2_reg & ~cs_s3_reg;
  assign op_ok = frame_end && tog_s2_reg != tog_seen_reg && !busy_flag_out;
  assign hw_lock_now = status_lock_bit_out & ~wp_s2_reg;
  assign go_latch = op_ok && opc_reg == LATCH_SET_CMD && cnt_reg == EDGE_OPC_END;
  assign go_status = op_ok && opc_reg == STATUS_UPDATE_CMD && cnt_reg == EDGE_STATUS_END &&
                     write_enable_latch_out && !hw_lock_now;
  assign go_sect = op_ok && opc_reg == FOUR_KIB_WIPE_CMD && cnt_reg == EDGE_ADDR_END &&
                   write_enable_latch_out;
  assign go_half = op_ok && opc_reg == HALF_BLOCK_WIPE_CMD && cnt_reg == EDGE_ADDR_END &&
                   write_enable_latch_out;
  assign level = {protect_level_top_out, protect_level_mid_out, protect_level_low_out};
  // any address in the sector or block selects it
  assign wipe_mask = go_half ? HALF_MASK : SECT_MASK;
  assign wipe_first = addr_reg[ADDR_W-1:0] & ~wipe_mask;
  assign wipe_last = addr_reg[ADDR_W-1:0] | wipe_mask;
  // region is top-aligned, so the range end decides
  assign wipe_prot = sfp_in_region(24'(wipe_last), level, ADDR_W);

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tog_seen_reg <= 1'b0;
    end else if (frame_end) begin
      tog_seen_reg <= tog_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Status and lock bits
  // ----------------------------------------------------------------
  logic lock_reg;
  logic [2:0] level_reg;
  logic hw_locked_reg;
  logic sw_locked_reg;

  // software locked state accepts the update
  // field positions of the status byte
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lock_reg <= LOCK_RESET;
      level_reg <= LEVEL_RESET;
    end else if (go_status) begin
      lock_reg <= addr_reg[ST_LOCK];
      level_reg <= {addr_reg[ST_TOP], addr_reg[ST_MID], addr_reg[ST_LOW]};
    end
  end

  // pin high leaves hardware locked state
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hw_locked_reg <= 1'b0;
      sw_locked_reg <= 1'b1;
    end else begin
      hw_locked_reg <= hw_lock_now;
      sw_locked_reg <= ~hw_lock_now;
    end
  end

  assign status_lock_bit_out = lock_reg;
  assign protect_level_top_out = level_reg[2];
  assign protect_level_mid_out = level_reg[1];
  assign protect_level_low_out = level_reg[0];
  assign hardware_locked_state_out = hw_locked_reg;
  assign software_locked_state_out = sw_locked_reg;

  // ----------------------------------------------------------------
  // Self-timed cycle engine
  // ----------------------------------------------------------------
  sfp_eng_t eng_reg;
  logic busy_reg;
  logic latch_reg;
  logic [ADDR_W-1:0] ptr_reg;
  logic [ADDR_W-1:0] last_reg;
  logic [31:0] timer_reg;
  logic start_wipe;

  assign start_wipe = (go_sect || go_half) && !wipe_prot;

  // busy and latch clear together at the end
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      eng_reg <= ENG_IDLE;
      busy_reg <= 1'b0;
    end else begin
      unique case (eng_reg)
        ENG_IDLE: begin
          if (start_wipe) begin
            eng_reg <= ENG_WIPE;
            busy_reg <= 1'b1;
          end else if (go_status) begin
            eng_reg <= ENG_WAIT;
            busy_reg <= 1'b1;
          end
        end
        ENG_WIPE: begin
          if (ptr_reg == last_reg) begin
            eng_reg <= ENG_WAIT;
          end
        end
        ENG_WAIT: begin
          if (timer_reg == '0) begin
            eng_reg <= ENG_IDLE;
            busy_reg <= 1'b0;
          end
        end
        default: begin
          eng_reg <= ENG_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // half-block or sector range, one byte per clock
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ptr_reg <= '0;
      last_reg <= '0;
    end else if (eng_reg == ENG_IDLE && start_wipe) begin
      ptr_reg <= wipe_first;
      last_reg <= wipe_last;
    end else if (eng_reg == ENG_WIPE && ptr_reg != last_reg) begin
      ptr_reg <= ptr_reg + ADDR_W'(1);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer_reg <= '0;
    end else if (eng_reg == ENG_IDLE && go_half) begin
      timer_reg <= 32'(HALF_BLOCK_WIPE_CYC - 1);
    end else if (eng_reg == ENG_IDLE && go_sect) begin
      timer_reg <= 32'(SECTOR_WIPE_CYC - 1);
    end else if (eng_reg == ENG_IDLE && go_status) begin
      timer_reg <= 32'(STATUS_UPDATE_CYC - 1);
    end else if (eng_reg != ENG_IDLE && timer_reg != '0) begin
      timer_reg <= timer_reg - 32'h1;
    end
  end

  // protected wipe still drops the latch
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      latch_reg <= 1'b0;
    end else if (go_latch) begin
      latch_reg <= 1'b1;
    end else if ((go_sect || go_half) && wipe_prot) begin
      latch_reg <= 1'b0;
    end else if (eng_reg == ENG_WAIT && timer_reg == '0) begin
      latch_reg <= 1'b0;
    end
  end

  assign busy_flag_out = busy_reg;
  assign write_enable_latch_out = latch_reg;

  // ----------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;

  // Wipe has priority; preload is for filling the array between frames
  assign wr_en = eng_reg == ENG_WIPE || load_en_in;
  assign wr_addr = eng_reg == ENG_WIPE ? ptr_reg : load_addr_in;
  assign wr_data = eng_reg == ENG_WIPE ? ERASED_BYTE : load_data_in;

  // Read path crosses unsynchronised: safe since reads are refused while busy
  sfp_array #(
    .ADDR_W(ADDR_W)
  ) u_array (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .wr_en_in(wr_en),
    .wr_addr_in(wr_addr),
    .wr_data_in(wr_data),
    .rd_addr_in(addr_reg[ADDR_W-1:0]),
    .rd_data_out(rd_data)
  );

endmodule : sfp_flash_core

//--- pkg/sfp_pkg.sv
// Constants, opcodes and helpers shared by the serial flash sequencer
package sfp_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] READ_CMD = 8'h03;
  localparam logic [7:0] FAST_READ_CMD = 8'h0B;
  localparam logic [7:0] DUAL_OUTPUT_READ_CMD = 8'h3B;
  localparam logic [7:0] DUAL_IO_READ_CMD = 8'hBB;
  localparam logic [7:0] FOUR_KIB_WIPE_CMD = 8'h20;
  localparam logic [7:0] HALF_BLOCK_WIPE_CMD = 8'h52;
  localparam logic [7:0] LATCH_SET_CMD = 8'h06;
  localparam logic [7:0] STATUS_UPDATE_CMD = 8'h01;

  // ----------------------------------------------------------------
  // Frame edge counts (rising edges of the link clock)
  // ----------------------------------------------------------------
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] CNT_MAX = 7'h7F;
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
  localparam logic [CNT_W-1:0] EDGE_OPC_LAST = 7'h07;
  localparam logic [CNT_W-1:0] EDGE_OPC_END = 7'h08;
  localparam logic [CNT_W-1:0] EDGE_STATUS_END = 7'h10;
  localparam logic [CNT_W-1:0] EDGE_ADDR_END = 7'h20;
  localparam logic [CNT_W-1:0] EDGE_DIO_ADDR_END = 7'h14;
  localparam logic [CNT_W-1:0] EDGE_DUMMY8_END = 7'h28;
  localparam logic [CNT_W-1:0] EDGE_DIO_DUMMY_END = 7'h18;
  localparam logic [2:0] DPOS_LAST_SGL = 3'h7;
  localparam logic [2:0] DPOS_LAST_DUAL = 3'h3;

  // ----------------------------------------------------------------
  // Status byte layout and array geometry
  // ----------------------------------------------------------------
  localparam int ST_LOCK = 7;
  localparam int ST_TOP = 5;
  localparam int ST_MID = 3;
  localparam int ST_LOW = 2;
  localparam logic LOCK_RESET = 1'b0;
  localparam logic [2:0] LEVEL_RESET = 3'h0;
  localparam logic [2:0] LEVEL_NONE = 3'h0;
  localparam logic [2:0] LEVEL_WHOLE = 3'h4;
  localparam int SFP_ADDR_W = 17;
  localparam int SECTOR_SHIFT = 12;
  localparam int HALF_BLOCK_SHIFT = 15;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int SYS_CLK_MHZ = 50;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_WIPE = 2'b01,
    ENG_WAIT = 2'b11
  } sfp_eng_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic sfp_is_read(input logic [7:0] opc);
    return opc == READ_CMD || opc == FAST_READ_CMD ||
           opc == DUAL_OUTPUT_READ_CMD || opc == DUAL_IO_READ_CMD;
  endfunction : sfp_is_read

  function automatic logic sfp_is_dual(input logic [7:0] opc);
    return opc == DUAL_OUTPUT_READ_CMD || opc == DUAL_IO_READ_CMD;
  endfunction : sfp_is_dual

  function automatic logic [CNT_W-1:0] sfp_data_start(input logic [7:0] opc);
    logic [CNT_W-1:0] s;
    s = EDGE_ADDR_END;
    if (opc == FAST_READ_CMD || opc == DUAL_OUTPUT_READ_CMD) begin
      s = EDGE_DUMMY8_END;
    end else if (opc == DUAL_IO_READ_CMD) begin
      s = EDGE_DIO_DUMMY_END;
    end
    return s;
  endfunction : sfp_data_start

  // Protected region grows downward from the top of the array
  function automatic logic sfp_in_region(input logic [23:0] last, input logic [2:0] lvl,
                                         input int aw);
    logic [24:0] span;
    logic [24:0] bound;
    span = 25'h1 << aw;
    bound = span - (span >> (LEVEL_WHOLE - lvl));
    if (lvl == LEVEL_NONE) begin
      return 1'b0;
    end
    if (lvl >= LEVEL_WHOLE) begin
      return 1'b1;
    end
    return {1'b0, last} >= bound;
  endfunction : sfp_in_region

endpackage : sfp_pkg

//--- tb/sfp_flash_core_props.sv
// Port checks for the serial flash command logic
`timescale 1ns/1ps
module sfp_flash_core_props (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic cs_b_in,
  input wire logic wp_b_in,
  input wire logic io_line_zero_oe_out,
  input wire logic io_line_one_oe_out,
  input wire logic status_lock_bit_out,
  input wire logic protect_level_top_out,
  input wire logic protect_level_mid_out,
  input wire logic protect_level_low_out,
  input wire logic write_enable_latch_out,
  input wire logic busy_flag_out,
  input wire logic hardware_locked_state_out,
  input wire logic software_locked_state_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  logic [3:0] lv;
  assign lv = {status_lock_bit_out, protect_level_top_out, protect_level_mid_out,
    protect_level_low_out};
  a_hw_enter: assert property (
    (status_lock_bit_out && !wp_b_in) [*5] |-> hardware_locked_state_out) else $error("no lock");
  a_hw_exit: assert property (
    wp_b_in [*5] |-> !hardware_locked_state_out) else $error("lock kept");
  a_mode_excl: assert property (
    software_locked_state_out != hardware_locked_state_out) else $error("mode clash");
  a_hw_freeze: assert property (
    hardware_locked_state_out [*2] |=> $stable(lv)) else $error("status changed");
  a_busy_end: assert property (
    $fell(busy_flag_out) |-> $fell(write_enable_latch_out)) else $error("latch kept");
  a_busy_latch: assert property (
    busy_flag_out |-> write_enable_latch_out) else $error("busy without latch");
  a_busy_hold: assert property (
    $rose(busy_flag_out) |-> busy_flag_out [*8]) else $error("busy too short");
  a_cs_release: assert property (
    cs_b_in |-> !io_line_one_oe_out && !io_line_zero_oe_out) else $error("line driven");
  a_busy_quiet: assert property (
    busy_flag_out |-> !io_line_one_oe_out) else $error("read while busy");
  a_dual_pair: assert property (
    io_line_zero_oe_out |-> io_line_one_oe_out) else $error("line zero alone");
  c_busy: cover property ($rose(busy_flag_out));
  c_lock: cover property ($rose(hardware_locked_state_out));
  c_dual: cover property ($rose(io_line_zero_oe_out));
endmodule : sfp_flash_core_props
bind sfp_flash_core sfp_flash_core_props u_props (.sys_clk_in, .rst_b_in, .cs_b_in,
  .wp_b_in, .io_line_zero_oe_out, .io_line_one_oe_out, .status_lock_bit_out,
  .protect_level_top_out, .protect_level_mid_out, .protect_level_low_out,
  .write_enable_latch_out, .busy_flag_out, .hardware_locked_state_out,
  .software_locked_state_out);

//--- tb/sfp_host_model.sv
// Host serial controller model
`timescale 1ns/1ps
module sfp_host_model (
  input wire logic d0_in,
  input wire logic oe0_in,
  input wire logic d1_in,
  input wire logic oe1_in,
  output logic sclk_out = 1'b0,
  output logic cs_b_out = 1'b1,
  output logic line0_out,
  output logic line1_out,
  output logic [7:0] byte_out = 8'h00,
  output logic byte_tgl_out = 1'b0
);
  logic h0 = 1'b0;
  logic h1 = 1'b1;
  // Released lines toggle past the address phase; line one holds its bit before that in single mode
  assign line0_out = oe0_in ? d0_in : h0;
  assign line1_out = oe1_in ? d1_in : h1;
  // ----
  // Frame: m 0 single, 1 dual data, 2 dual address and data
  // ----
  task automatic frame(input logic [7:0] opc, input logic [23:0] a, input int nb,
    input int nd, input int nr, input int m);
    logic [31:0] sh;
    int s;
    int k;
    sh = {opc, a};
    s = 8 + nb + nd;
    #13 cs_b_out = 1'b0;
    for (k = 0; k < s + nr * (m ? 4 : 8); k++) begin
      #20;
      if (k < 8 + nb) begin
        {h1, h0} = (k >= 8 && m == 2) ? sh[31:30] : {h1, sh[31]};
        sh = (k >= 8 && m == 2) ? sh << 2 : sh << 1;
      end else begin
        {h1, h0} = ~{h1, h0};
      end
      #20 sclk_out = 1'b1;
      if (k >= s && oe1_in) begin
        byte_out = m ? {byte_out[5:0], line1_out, line0_out} : {byte_out[6:0], line1_out};
        if ((k - s) % (m ? 4 : 8) == (m ? 3 : 7)) byte_tgl_out = ~byte_tgl_out;
      end
      #40 sclk_out = 1'b0;
    end
    #20 cs_b_out = 1'b1;
    #200;
  endtask : frame
endmodule : sfp_host_model

//--- tb/tb.sv
// Self-checking bench for the serial flash command logic
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
  import sfp_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic wp_b_in = 1'b1;
  logic ld_en = 1'b0;
  logic [15:0] ld_a = 16'h0000;
  logic [7:0] ld_d = 8'h00;
  logic sclk, cs_b, l0, l1, d0, oe0, d1, oe1, lock, top, mid, low, write_enable_latch, busy, hw, sw, tgl;
  logic [7:0] rb, e;
  logic [7:0] q[$];
  logic [7:0] r[3];
  logic [7:0] opcs[4] = '{READ_CMD, FAST_READ_CMD, DUAL_OUTPUT_READ_CMD, DUAL_IO_READ_CMD};
  int nbs[4] = '{24, 24, 24, 12};
  int nds[4] = '{0, 8, 8, 4};
  int ms[4] = '{0, 0, 1, 2};
  logic [31:0] seed = 32'hA996E5C6;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  always #10 sys_clk_in = ~sys_clk_in;
  sfp_flash_core #(.ADDR_W(16), .SECTOR_WIPE_TIME_US(1), .HALF_BLOCK_WIPE_TIME_US(1),
    .STATUS_UPDATE_TIME_US(1)) DUT (.sys_clk_in, .rst_b_in, .sclk_in(sclk), .cs_b_in(cs_b),
    .wp_b_in, .io_line_zero_in(l0), .io_line_one_in(l1), .io_line_zero_out(d0),
    .io_line_zero_oe_out(oe0), .io_line_one_out(d1), .io_line_one_oe_out(oe1),
    .load_en_in(ld_en), .load_addr_in(ld_a), .load_data_in(ld_d), .status_lock_bit_out(lock),
    .protect_level_top_out(top), .protect_level_mid_out(mid), .protect_level_low_out(low),
    .write_enable_latch_out(write_enable_latch), .busy_flag_out(busy), .hardware_locked_state_out(hw),
    .software_locked_state_out(sw));
  sfp_host_model host (.d0_in(d0), .oe0_in(oe0), .d1_in(d1), .oe1_in(oe1), .sclk_out(sclk),
    .cs_b_out(cs_b), .line0_out(l0), .line1_out(l1), .byte_out(rb), .byte_tgl_out(tgl));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #2;
  endtask : tick
  task automatic load(input logic [15:0] a, input logic [7:0] d);
    ld_en = 1'b1;
    ld_a = a;
    ld_d = d;
    tick(1);
    ld_en = 1'b0;
  endtask : load
  task automatic lset();
    host.frame(LATCH_SET_CMD, 24'h000000, 0, 0, 0, 0);
    tick(6);
  endtask : lset
  task automatic st(input logic [7:0] v);
    lset();
    host.frame(STATUS_UPDATE_CMD, {v, 16'h0000}, 8, 0, 0, 0);
    tick(10);
  endtask : st
  task automatic wipe(input logic [7:0] c, input logic [23:0] a, input int nb);
    host.frame(c, a, nb, 0, 0, 0);
    tick(10);
  endtask : wipe
  task automatic wait_idle();
    for (int i = 0; i < 40000 && busy !== 1'b0; i++) tick(1);
    tick(2);
  endtask : wait_idle
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  // Unexpected bytes count as mismatches
  always @(tgl) begin
    // Power-up settling of the toggle is not a byte
    if (rst_b_in !== 1'b1) begin
    end else if (q.size() == 0) begin
      n_fail++;
      $display("mismatch read byte exp none got %h", rb);
    end else begin
      e = q.pop_front();
      `CHK("read byte", e, rb)
    end
  end
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      wrap_up();
    end
  end
  // ----
  // Main sequence
  // ----
  initial begin
    tick(6);
    rst_b_in = 1'b1;
    tick(4);
    `CHK("reset status", 8'h01, {lock, top, mid, low, write_enable_latch, busy, hw, sw})
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      r[i] = seed[7:0] & 8'h7F;
    end
    load(16'hFFFF, r[0]);
    load(16'h0000, r[1]);
    load(16'h1FFF, r[2]);
    load(16'h2000, r[1]);
    for (int i = 0; i < 4; i++) begin
      q = {q, r[0], r[1]};
      host.frame(opcs[i], 24'h00FFFF, nbs[i], nds[i], 2, ms[i]);
    end
    $display("test reads done");
    lset();
    `CHK("latch", 1'b1, write_enable_latch)
    wipe(FOUR_KIB_WIPE_CMD, 24'h001234, 16);
    `CHK("short wipe", 1'b0, busy)
    wipe(FOUR_KIB_WIPE_CMD, 24'h001234, 24);
    `CHK("wipe busy", 1'b1, busy)
    host.frame(READ_CMD, 24'h00FFFF, 24, 0, 1, 0);
    wait_idle();
    `CHK("wipe latch", 1'b0, write_enable_latch)
    q = {q, 8'hFF, r[1]};
    host.frame(READ_CMD, 24'h001FFF, 24, 0, 2, 0);
    wipe(FOUR_KIB_WIPE_CMD, 24'h002000, 24);
    `CHK("no latch", 1'b0, busy)
    $display("test sector wipe done");
    st(8'h04);
    wait_idle();
    `CHK("levels", 5'b00010, {lock, top, mid, low, write_enable_latch})
    lset();
    wipe(HALF_BLOCK_WIPE_CMD, 24'h00F000, 24);
    `CHK("protected", 2'b00, {busy, write_enable_latch})
    lset();
    wipe(HALF_BLOCK_WIPE_CMD, 24'h000000, 24);
    `CHK("half busy", 1'b1, busy)
    wait_idle();
    `CHK("half latch", 1'b0, write_enable_latch)
    q = {q, r[0], 8'hFF};
    host.frame(READ_CMD, 24'h00FFFF, 24, 0, 2, 0);
    $display("test half block done");
    st(8'h84);
    wait_idle();
    `CHK("lock pin high", 3'b101, {lock, hw, sw})
    wp_b_in = 1'b0;
    tick(8);
    `CHK("hw lock", 2'b10, {hw, sw})
    st(8'h00);
    `CHK("frozen", 6'b100110, {lock, top, mid, low, write_enable_latch, busy})
    wp_b_in = 1'b1;
    tick(8);
    `CHK("hw exit", 1'b0, hw)
    st(8'h00);
    wait_idle();
    `CHK("unlock", 4'h0, {lock, top, mid, low})
    wp_b_in = 1'b0;
    tick(8);
    st(8'h84);
    wait_idle();
    `CHK("pin first", 1'b1, hw)
    `CHK("queue empty", 0, q.size())
    $display("test locking done");
    wrap_up();
  end
endmodule : tb
